// *** tce_timer.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module tce_timer (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      ce,
   input  wire tce_pkg::tce_bus_req_type  bus_req,
   output logic [tce_pkg::DATA_W-1:0]     rdata,
   input  wire logic [tce_pkg::NUM_PINS-1:0] count_pins,
   output logic [tce_pkg::NUM_CHAN-1:0]   compare_one_irq
);
   import tce_pkg::*;

   typedef struct packed {
      tce_chan_type [NUM_CHAN-1:0] ch;
      logic [NUM_CHAN-1:0]         chan_run_bits;
      logic [DATA_W-1:0]           rdata;
   } tce_st_type;

   tce_st_type st_r;
   tce_st_type st_nxt;

   logic [NUM_CHAN-1:0][NUM_PINS-1:0] filt_lvl;

   function automatic logic chan_hit(logic [ADDR_W-1:0] a,
                                     logic [1:0] c,
                                     logic [4:0] off);
      return a == {1'b0, c, off};
   endfunction

   function automatic logic pick(logic [NUM_PINS-1:0] v, logic [1:0] s);
      return v[s];
   endfunction

   // Divide by 2**k: tick when the low k prescaler bits are all ones.
   function automatic logic presc_tick(logic [PRESC_W-1:0] p,
                                       logic [2:0] k);
      logic [7:0] m;
      m = (8'h01 << k) - 8'h01;
      return &(p | ~m[PRESC_W-1:0]);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_filt
         tce_in_filter #(
            .NPINS (NUM_PINS)
         ) u_filt (
            .clk     (clk),
            .reset_n (reset_n),
            .ce      (ce),
            .pins    (count_pins),
            .input_filter_on (st_r.ch[gi].compare_status_control[CS_FILT_BIT]),
            .lvl     (filt_lvl[gi])
         );
      end
   endgenerate

   always_comb begin
      logic [2:0] mode;
      logic [3:0] primary_source_select;
      logic [1:0] secondary_source_select;
      logic       input_polarity_invert;
      logic       is_ext;
      logic       is_int;
      logic       cur;
      logic       prv;
      logic       rise;
      logic       both;
      logic       prim;
      logic       gate;
      logic       ev;
      logic       match;
      logic       wsel;
      mode   = MODE_STOP;
      primary_source_select    = 4'h0;
      secondary_source_select    = 2'h0;
      input_polarity_invert    = 1'b0;
      is_ext = 1'b0;
      is_int = 1'b0;
      cur    = 1'b0;
      prv    = 1'b0;
      rise   = 1'b0;
      both   = 1'b0;
      prim   = 1'b0;
      gate   = 1'b0;
      ev     = 1'b0;
      match  = 1'b0;
      wsel   = 1'b0;
      st_nxt = st_r;
      st_nxt.rdata = '0;

      if (bus_req.wr && bus_req.addr == OFF_CHAN_ENABLE) begin
         st_nxt.chan_run_bits = bus_req.wdata[NUM_CHAN-1:0];
      end

      for (int i = 0; i < NUM_CHAN; i++) begin
         mode   = st_r.ch[i].ctrl[CTRL_MODE_LSB +: 3];
         primary_source_select    = st_r.ch[i].ctrl[CTRL_PCS_LSB +: 4];
         secondary_source_select    = st_r.ch[i].ctrl[CTRL_SCS_LSB +: 2];
         input_polarity_invert    = st_r.ch[i].ctrl[CTRL_IPS_BIT];
         is_ext = primary_source_select <= PCS_PIN_LAST;
         is_int = primary_source_select >= PCS_INT_BASE;

         cur  = pick(filt_lvl[i], primary_source_select[1:0]);
         prv  = pick(st_r.ch[i].prev, primary_source_select[1:0]);
         rise = (cur ^ input_polarity_invert) & ~(prv ^ input_polarity_invert);
         both = cur ^ prv;
         st_nxt.ch[i].prev = filt_lvl[i];

         prim = is_ext ? rise
                       : (is_int & presc_tick(st_r.ch[i].presc, primary_source_select[2:0]));
         gate = pick(filt_lvl[i], secondary_source_select) ^ input_polarity_invert;

         case (mode)
            MODE_RISE: begin
               ev = prim;
            end
            MODE_BOTH: begin
               ev = is_ext & both;
            end
            MODE_GATED: begin
               ev = prim & gate;
            end
            MODE_STOP: begin
               ev = 1'b0;
            end
            default: begin
               ev = 1'b0;
            end
         endcase

         ev = ev & st_r.chan_run_bits[i];

         if (st_r.chan_run_bits[i]) begin
            st_nxt.ch[i].presc = st_r.ch[i].presc + 7'h01;
         end

         match = ev & (st_r.ch[i].cntr == st_r.ch[i].compare_one);
         if (ev) begin
            if (match && st_r.ch[i].ctrl[CTRL_LENGTH_BIT]) begin
               st_nxt.ch[i].cntr = st_r.ch[i].load;
            end else begin
               st_nxt.ch[i].cntr = st_r.ch[i].cntr + 16'h0001;
            end
         end
         if (match &&
             st_r.ch[i].compare_status_control[CS_CL1_LSB +: 2] == CL1_ON_COMPARE_ONE) begin
            st_nxt.ch[i].compare_one = st_r.ch[i].compare_one_preload;
         end
         if (match && st_r.ch[i].ctrl[CTRL_ONCE_BIT] &&
             st_r.ch[i].ctrl[CTRL_LENGTH_BIT]) begin
            st_nxt.ch[i].ctrl[CTRL_MODE_LSB +: 3] = MODE_STOP;
         end

         // Software writes land after counting, so a write wins over it; a match still sets the compare flag over a flag-clearing write.
         if (bus_req.wr) begin
            if (chan_hit(bus_req.addr, 2'(i), OFF_CTRL)) begin
               st_nxt.ch[i].ctrl = bus_req.wdata & CTRL_WMASK;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_CNTR)) begin
               st_nxt.ch[i].cntr = bus_req.wdata;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_ONE)) begin
               st_nxt.ch[i].compare_one = bus_req.wdata;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_ONE_PRELOAD)) begin
               st_nxt.ch[i].compare_one_preload = bus_req.wdata;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_LOAD)) begin
               st_nxt.ch[i].load = bus_req.wdata;
            end
         end
         wsel = bus_req.wr && chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_STATUS_CONTROL);
         if (wsel) begin
            st_nxt.ch[i].compare_status_control = (bus_req.wdata & CS_WMASK) |
                                  (st_r.ch[i].compare_status_control & ~CS_WMASK);
            if (!bus_req.wdata[CS_COMPARE_ONE_FLAG_BIT]) begin
               st_nxt.ch[i].compare_status_control[CS_COMPARE_ONE_FLAG_BIT] = 1'b0;
            end
         end
         if (match) begin
            st_nxt.ch[i].compare_status_control[CS_COMPARE_ONE_FLAG_BIT] = 1'b1;
         end

         if (bus_req.rd) begin
            if (chan_hit(bus_req.addr, 2'(i), OFF_CTRL)) begin
               st_nxt.rdata = st_r.ch[i].ctrl;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_CNTR)) begin
               st_nxt.rdata = st_r.ch[i].cntr;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_ONE)) begin
               st_nxt.rdata = st_r.ch[i].compare_one;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_ONE_PRELOAD)) begin
               st_nxt.rdata = st_r.ch[i].compare_one_preload;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_LOAD)) begin
               st_nxt.rdata = st_r.ch[i].load;
            end
            if (chan_hit(bus_req.addr, 2'(i), OFF_COMPARE_STATUS_CONTROL)) begin
               st_nxt.rdata = st_r.ch[i].compare_status_control;
            end
         end
      end

      if (bus_req.rd && bus_req.addr == OFF_CHAN_ENABLE) begin
         st_nxt.rdata = {{(DATA_W-NUM_CHAN){1'b0}}, st_r.chan_run_bits};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.chan_run_bits <= CHAN_ENABLE_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;

   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_irq
         assign compare_one_irq[gi] = st_r.ch[gi].compare_status_control[CS_COMPARE_ONE_FLAG_BIT] &
                                      st_r.ch[gi].compare_status_control[CS_TCF1EN_BIT];
      end
   endgenerate

endmodule // tce_timer

// *** tce_pkg.sv ***
package tce_pkg;

   localparam int NUM_CHAN = 4;
   localparam int NUM_PINS = 4;
   localparam int DATA_W   = 16;
   localparam int ADDR_W   = 8;

   // Channel register windows sit one stride apart.
   localparam logic [4:0] OFF_COMPARE_ONE       = 5'h00;
   localparam logic [4:0] OFF_LOAD        = 5'h03;
   localparam logic [4:0] OFF_CNTR        = 5'h05;
   localparam logic [4:0] OFF_CTRL        = 5'h06;
   localparam logic [4:0] OFF_COMPARE_ONE_PRELOAD      = 5'h10;
   localparam logic [4:0] OFF_COMPARE_STATUS_CONTROL      = 5'h14;
   localparam logic [7:0] OFF_CHAN_ENABLE = 8'h1e;

   // Control register fields.
   localparam int CTRL_MODE_LSB   = 13;
   localparam int CTRL_PCS_LSB    = 9;
   localparam int CTRL_SCS_LSB    = 7;
   localparam int CTRL_ONCE_BIT   = 6;
   localparam int CTRL_LENGTH_BIT = 5;
   localparam int CTRL_IPS_BIT    = 0;
   localparam logic [15:0] CTRL_WMASK = 16'hffe1;

   // Compare status control fields.
   localparam int CS_FILT_BIT   = 13;
   localparam int CS_TCF1EN_BIT = 6;
   localparam int CS_COMPARE_ONE_FLAG_BIT   = 4;
   localparam int CS_CL1_LSB    = 0;
   localparam logic [15:0] CS_WMASK = 16'h20cf;

   localparam logic [3:0]  CHAN_ENABLE_RST = 4'hf;
   localparam logic [15:0] REG_RST         = 16'h0000;

   localparam logic [2:0] MODE_STOP   = 3'h0;
   localparam logic [2:0] MODE_RISE   = 3'h1;
   localparam logic [2:0] MODE_BOTH   = 3'h2;
   localparam logic [2:0] MODE_GATED  = 3'h3;
   localparam logic [1:0] CL1_ON_COMPARE_ONE = 2'h1;

   // Source select values 8..15 pick clk divided by 2**(value-8).
   localparam logic [3:0] PCS_PIN_LAST = 4'h3;
   localparam logic [3:0] PCS_INT_BASE = 4'h8;
   localparam int         PRESC_W      = 7;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tce_bus_req_type;

   typedef struct packed {
      logic [15:0]        ctrl;
      logic [15:0]        compare_status_control;
      logic [15:0]        compare_one;
      logic [15:0]        compare_one_preload;
      logic [15:0]        load;
      logic [15:0]        cntr;
      logic [PRESC_W-1:0] presc;
      logic [NUM_PINS-1:0] prev;
   } tce_chan_type;

endpackage

// *** tce_in_filter.sv ***
`timescale 1ns/1ns
module tce_in_filter #(
   parameter int NPINS = 4
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic [NPINS-1:0] pins,
   input  wire logic             input_filter_on,
   output logic      [NPINS-1:0] lvl
);
   import tce_pkg::*;

   typedef struct packed {
      logic [NPINS-1:0] samp;
      logic [NPINS-1:0] h1;
      logic [NPINS-1:0] h2;
      logic [NPINS-1:0] out;
   } tce_filt_st_type;

   tce_filt_st_type st_r;
   tce_filt_st_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.samp = pins;
      st_nxt.h1   = st_r.samp;
      st_nxt.h2   = st_r.h1;
      for (int b = 0; b < NPINS; b++) begin
         if (!input_filter_on) begin
            st_nxt.out[b] = st_r.samp[b];
         end else if (st_r.samp[b] == st_r.h1[b] &&
                      st_r.h1[b] == st_r.h2[b]) begin
            st_nxt.out[b] = st_r.samp[b];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign lvl = st_r.out;

endmodule // tce_in_filter

// *** tce_timer_chk.sv ***
`timescale 1ns/1ns
module tce_timer_chk (
   input wire logic                            clk,
   input wire logic                            reset_n,
   input wire logic                            ce,
   input wire tce_pkg::tce_bus_req_type        bus_req,
   input wire logic [tce_pkg::DATA_W-1:0]      rdata,
   input wire logic [tce_pkg::NUM_PINS-1:0]    count_pins,
   input wire logic [tce_pkg::NUM_CHAN-1:0]    compare_one_irq
);
   import tce_pkg::*;
   logic [3:0] en_r;
   logic [2:0] md_r;
   logic       cs_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !ce);
   sequence s_rd(logic [7:0] a);
      bus_req.rd && bus_req.addr == a;
   endsequence
   sequence s_cs_wr;
      bus_req.wr && bus_req.addr == 8'h14;
   endsequence
   // Shadows follow software writes only; hardware may clear mode to zero.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         en_r <= CHAN_ENABLE_RST;
         md_r <= MODE_STOP;
         cs_r <= 1'b0;
      end else if (ce && bus_req.wr) begin
         if (bus_req.addr == OFF_CHAN_ENABLE) en_r <= bus_req.wdata[3:0];
         if (bus_req.addr == 8'h06) md_r <= bus_req.wdata[15:13];
         if (bus_req.addr[4:0] == OFF_COMPARE_STATUS_CONTROL) cs_r <= 1'b1;
      end
   end
   chk_rdata_idle: assert property (
      !$past(bus_req.rd) |-> rdata == '0) else $error("rdata without read");
   chk_enable_read: assert property (
      s_rd(OFF_CHAN_ENABLE) |=> rdata == {12'h000, $past(en_r)})
      else $error("enable register read wrong");
   chk_unmapped_zero: assert property (
      bus_req.rd && !(bus_req.addr[4:0] inside {5'h00, 5'h03, 5'h05,
      5'h06, 5'h10, 5'h14, 5'h1e}) |=> rdata == '0)
      else $error("unmapped read not zero");
   chk_cs_reserved: assert property (
      bus_req.rd && bus_req.addr[4:0] == OFF_COMPARE_STATUS_CONTROL |=>
      (rdata & ~(CS_WMASK | (16'h0001 << CS_COMPARE_ONE_FLAG_BIT))) == '0)
      else $error("compare_status_control reserved bits set");
   chk_flag_clear: assert property (
      $fell(compare_one_irq[0]) |-> $past(bus_req.wr)
      && $past(bus_req.addr) == 8'h14) else $error("flag fell alone");
   chk_irq_quiet: assert property (
      !cs_r |-> compare_one_irq == '0) else $error("irq before setup");
   chk_irq_needs_en: assert property (
      $rose(compare_one_irq[0]) && !$past(bus_req.wr && bus_req.addr
      == 8'h14) |-> $past(en_r[0])) else $error("disabled count");
   chk_irq_needs_mode: assert property (
      $rose(compare_one_irq[0]) && !$past(bus_req.wr && bus_req.addr
      == 8'h14) |-> $past(md_r) != MODE_STOP)
      else $error("count in stop mode");
endmodule // tce_timer_chk

bind tce_timer tce_timer_chk i_chk (.clk(clk), .reset_n(reset_n), .ce(ce),
   .bus_req(bus_req), .rdata(rdata), .count_pins(count_pins),
   .compare_one_irq(compare_one_irq));

// *** tce_pin_model.sv ***
`timescale 1ns/1ns
module tce_pin_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       go,
   input  wire logic [1:0] sel,
   input  wire logic [7:0] pulses,
   input  wire logic [3:0] width,
   output logic      [3:0] count_pins,
   output logic            busy
);
   int   left;
   int   ph;
   logic lvl;
   // Pins rest low between bursts, so no stray edge reaches the counter.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left <= 0;
         ph <= 1;
         lvl <= 1'b0;
      end else if (go) begin
         left <= 2 * pulses;
         ph <= 1;
      end else if (left != 0) begin
         if (ph == width) begin
            ph <= 1;
            left <= left - 1;
            lvl <= ~lvl;
         end else begin
            ph <= ph + 1;
         end
      end
   end
   assign count_pins = {3'b000, lvl} << sel;
   assign busy = left != 0;
endmodule // tce_pin_model

// *** tce_timer_tb.sv ***
`timescale 1ns/1ns
module tce_timer_tb;
   import tce_pkg::*;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   logic            ce = 1'b1;
   tce_bus_req_type bus_req = '0;
   logic [15:0]     rdata;
   logic [3:0]      pins;
   logic [3:0]      irq;
   logic            go = 1'b0;
   logic [7:0]      npul = 8'h00;
   logic [3:0]      wid = 4'h2;
   logic            busy;
   logic [31:0]     lfsr = 32'haf4f;
   logic [15:0]     d;
   logic [15:0]     s0;
   int              n;
   int              error_cnt = 0;
   int              n_compared = 0;
   logic [15:0] tc [7] = '{16'h2200, 16'h2201, 16'h4200, 16'h7080,
                           16'h0200, 16'h2200, 16'h2200};
   logic [15:0] ts [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                           16'h2000, 16'h2000};
   int tw [7] = '{2, 2, 2, 3, 2, 2, 4};
   int tm [7] = '{1, 1, 2, 3, 0, 0, 1};

   tce_timer i_tce_timer (.clk(clk), .reset_n(reset_n), .ce(ce),
      .bus_req(bus_req), .rdata(rdata), .count_pins(pins),
      .compare_one_irq(irq));
   tce_pin_model i_tce_pin_model (.clk(clk), .reset_n(reset_n), .go(go),
      .sel(2'd1), .pulses(npul), .width(wid), .count_pins(pins),
      .busy(busy));

   always #2 clk = ~clk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus_req <= '0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [15:0] e);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
      @(posedge clk);
      bus_req <= '0;
      #1 d = rdata;
      chk(nm, e, d);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rchk("enable", 8'h1e, 16'h000f);
      for (int c = 0; c < 4; c++) begin
         rchk("ctrl", 8'(c * 32 + 6), 16'h0);
         rchk("compare_status_control", 8'(c * 32 + 20), 16'h0);
      end
      rchk("unmapped", 8'h1f, 16'h0);
      wr(8'h1e, 16'hfff0);
      rchk("enable", 8'h1e, 16'h0000);
      $display("test reset done");
      wr(8'h26, 16'h3e00);
      wr(8'h46, 16'h3000);
      wr(8'h66, 16'h3000);
      wr(8'h1e, 16'h000e);
      repeat (184) @(posedge clk);
      // Ten frozen cycles with the clock enable low must drop ten counts.
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      repeat (190) @(posedge clk);
      wr(8'h1e, 16'h0);
      rchk("ch2 cntr", 8'h45, 16'd376);
      rchk("ch3 cntr", 8'h65, 16'd376);
      rchk("ch1 cntr", 8'h25, 16'd3);
      chk("ch1 range", (d == 16'h2) ? 16'h2 : 16'h3, d);
      rchk("ch2 hold", 8'h45, 16'd376);
      rchk("ch1 hold", 8'h25, 16'd3);
      $display("test sync done");
      wr(8'h00, 16'h0004);
      wr(8'h10, 16'h0006);
      wr(8'h14, 16'h0041);
      wr(8'h06, 16'h3020);
      wr(8'h60, 16'h0003);
      wr(8'h65, 16'h0000);
      wr(8'h66, 16'h3060);
      wr(8'h1e, 16'h0009);
      for (int k = 0; k < 64 && irq[0] !== 1'b1; k++) @(posedge clk);
      if (irq[0] !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      wr(8'h1e, 16'h0);
      rchk("compare_one", 8'h00, 16'h0006);
      rchk("ch3 ctrl", 8'h66, 16'h1060);
      rchk("ch3 cntr", 8'h65, 16'h0000);
      wr(8'h14, 16'h0051);
      rchk("compare_status_control", 8'h14, 16'h0051);
      wr(8'h14, 16'h0041);
      #1 chk("irq", 16'(irq[0]), 16'h0);
      $display("test compare done");
      for (int i = 0; i < 7; i++) begin
         lfsr = lfsr_next(lfsr);
         s0 = lfsr[15:0];
         n = 1 + lfsr[18:16];
         wr(8'h25, s0);
         wr(8'h26, tc[i]);
         wr(8'h34, ts[i]);
         wr(8'h1e, 16'h0002);
         npul <= 8'(n);
         wid <= 4'(tw[i]);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         #1;
         for (int k = 0; k < 300 && busy; k++) @(posedge clk);
         if (busy) begin
            error_cnt++;
            stop_test();
         end
         repeat (8) @(posedge clk);
         wr(8'h1e, 16'h0);
         rchk("pin cntr", 8'h25, 16'(s0 + n * tm[i]));
      end
      $display("test pins done");
      stop_test();
   end
endmodule // tce_timer_tb
